// ### angle_sensor_spi_command_port.v
// Serial command port of the angle sensor: frame decode, registers, replies.
`timescale 1ns/1ps
`default_nettype none
`include "angle_spi_map.vh"
// Summary of operation
// - All frames shift most significant bit first, both directions.
// - Write frame: opcode, seven address bits, twelve data bits; output off.
// - Read frame: opcode, seven address bits, then twelve data bits returned.
// - Angle frame: mode, two parities, error, then twelve angle bits.
// - Mode flag is 0 in normal mode, 1 in user mode.
// - Upper parity covers angle bits 11..6, lower covers 5..0.
// - Parity is odd when healthy, even when abnormal.
// - Returned angle already has quadrature hysteresis applied.
// - Opcode 0001 writes memory word, 0010 reads memory word.
// - Opcode 0011 writes register, 0100 reads register.
// - Opcode 0101 changes between normal and user mode.
// - Opcode 1000 refreshes angle, flux, error monitor and error flag.
// - Opcode 1001 reads the angle frame.
// - Normal mode permits only angle renew, angle read, angle value register read and mode change.
// - User mode: 0x01, 0x03, 0x08 read-only; 0x06,0x07,0x09,0x0a writable.
// - Mode register changes only through the mode change opcode.
// - Flux strength reports field at about one count per millitesla.
// - Error monitor has one bit per error kind.
// - Mode value 0x000 selects normal, 0x50f selects user; normal default.
// - Device starts in normal mode after power-on.
module angle_sensor_spi_command_port (
    input wire sys_clk,
    input wire sys_rst,
    input wire spi_cs_n,
    input wire spi_sclk,
    input wire spi_mosi,
    output reg spi_miso_ff,
    output reg spi_miso_oe_ff,
    input wire [11:0] raw_angle,
    input wire [6:0] field_mt,
    input wire flux_fault,
    input wire tracking_lost,
    output reg user_mode_ff,
    output reg [11:0] zero_point_offset_ff,
    output reg [11:0] direction_quadrature_config_ff,
    output reg [11:0] fault_detect_disable_ff,
    output reg [11:0] commutation_config_ff
);
    function odd_par6;
        input [5:0] v;
        input abnormal;
        begin
            odd_par6 = ~(^v) ^ abnormal;
        end
    endfunction
    function [1:0] hys_lsb;
        input [2:0] code;
        begin
            case (code)
                3'h0: hys_lsb = 2'd0;
                3'h1: hys_lsb = 2'd0;
                3'h3: hys_lsb = 2'd2;
                3'h4: hys_lsb = 2'd3;
                default: hys_lsb = 2'd1;
            endcase
        end
    endfunction

    // Three-stage pin samplers; stage one feeds only stage two.
    reg [2:0] cs_sync_ff, sclk_sync_ff, mosi_sync_ff;
    reg cs_n_ff, sclk_ff, mosi_ff;
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cs_sync_ff <= 3'h7;
            sclk_sync_ff <= 3'h0;
            mosi_sync_ff <= 3'h0;
            cs_n_ff <= 1'b1;
            sclk_ff <= 1'b0;
            mosi_ff <= 1'b0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], spi_cs_n};
            sclk_sync_ff <= {sclk_sync_ff[1:0], spi_sclk};
            mosi_sync_ff <= {mosi_sync_ff[1:0], spi_mosi};
            if (cs_sync_ff[1] == cs_sync_ff[2]) begin
                cs_n_ff <= cs_sync_ff[2];
            end
            if (sclk_sync_ff[1] == sclk_sync_ff[2]) begin
                sclk_ff <= sclk_sync_ff[2];
            end
            if (mosi_sync_ff[1] == mosi_sync_ff[2]) begin
                mosi_ff <= mosi_sync_ff[2];
            end
        end
    end
    wire sclk_rise = ~sclk_ff & (sclk_sync_ff[1] == sclk_sync_ff[2])
        & sclk_sync_ff[2];
    wire sclk_fall = sclk_ff & (sclk_sync_ff[1] == sclk_sync_ff[2])
        & ~sclk_sync_ff[2];

    reg [4:0] bit_cnt_ff;
    reg [22:0] shift_in_ff;
    reg [15:0] shift_out_ff;
    reg [4:0] out_left_ff;
    reg [11:0] angle_value_ff;
    reg [6:0] flux_strength_ff;
    reg [1:0] error_monitor_ff;
    reg error_flag_ff;
    reg [11:0] memory_lock_state_ff;
    reg [11:0] held_angle_ff;
    reg mem_rd_pend_ff;
    wire [11:0] mem_rd_data;
    wire [10:0] opaddr = {shift_in_ff[9:0], mosi_ff};
    wire [6:0] addr = opaddr[6:0];
    wire [3:0] addr_op = opaddr[10:7];
    wire [22:0] frame = {shift_in_ff[21:0], mosi_ff};
    wire abnormal = ~error_flag_ff;

    // Hysteresis: the held angle only follows once the raw angle moves
    // farther than the configured band, so dither inside a nonzero band never reaches the frame; codes 0 and 1 give a band of zero.
    wire [1:0] band = hys_lsb(
        direction_quadrature_config_ff[`HYS_MSB+1:`HYS_LSB]);
    wire [11:0] diff_up = raw_angle - held_angle_ff;
    wire [11:0] diff_dn = held_angle_ff - raw_angle;
    wire hys_off = (direction_quadrature_config_ff[`HYS_MSB+1:`HYS_LSB]
        == 3'h0);
    wire move = hys_off || (diff_up > {10'h000, band})
        && (diff_dn > {10'h000, band});
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            held_angle_ff <= 12'h000;
        end else if (move) begin
            held_angle_ff <= raw_angle;
        end
    end

    // Register readback: angle value in either mode, the rest in user mode only; unavailable addresses give no reply.
    reg rd_ok;
    reg [11:0] rd_val;
    always @* begin
        rd_ok = 1'b1;
        rd_val = 12'h000;
        if (addr == `ADDR_ANGLE_VALUE) begin
            rd_val = angle_value_ff;
        end else if (!user_mode_ff) begin
            rd_ok = 1'b0;
        end else if (addr == `ADDR_FLUX_STRENGTH) begin
            rd_val = {5'h00, flux_strength_ff};
        end else if (addr == `ADDR_OPERATING_MODE_SELECT) begin
            rd_val = `MODE_USER_VALUE;
        end else if (addr == `ADDR_ERROR_MONITOR) begin
            rd_val = {10'h000, error_monitor_ff};
        end else if (addr == `ADDR_ZERO_POINT_OFFSET) begin
            rd_val = zero_point_offset_ff;
        end else if (addr == `ADDR_DIRECTION_QUADRATURE_CONFIG) begin
            rd_val = direction_quadrature_config_ff;
        end else if (addr == `ADDR_MEMORY_LOCK_STATE) begin
            rd_val = memory_lock_state_ff;
        end else if (addr == `ADDR_FAULT_DETECT_DISABLE) begin
            rd_val = fault_detect_disable_ff;
        end else if (addr == `ADDR_COMMUTATION_CONFIG) begin
            rd_val = commutation_config_ff;
        end else begin
            rd_ok = 1'b0;
        end
    end

    wire [15:0] angle_frame = {user_mode_ff,
        odd_par6(angle_value_ff[11:6], abnormal),
        odd_par6(angle_value_ff[5:0], abnormal),
        error_flag_ff, angle_value_ff};
    wire mem_we = sclk_rise && !cs_n_ff && bit_cnt_ff == `DATA_END_BIT - 1
        && frame[22:19] == `OP_MEM_WRITE && user_mode_ff
        && frame[18:16] == 3'h0;

    angle_spi_mem u_mem (
        .sys_clk(sys_clk),
        .wr_en(mem_we),
        .wr_addr(frame[15:12]),
        .wr_data(frame[11:0]),
        .rd_addr(addr[3:0]),
        .rd_data_ff(mem_rd_data)
    );

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            bit_cnt_ff <= 5'd0;
            shift_in_ff <= 23'h0;
            shift_out_ff <= 16'h0;
            out_left_ff <= 5'd0;
            spi_miso_ff <= 1'b0;
            spi_miso_oe_ff <= 1'b0;
            user_mode_ff <= 1'b0;
            angle_value_ff <= 12'h000;
            flux_strength_ff <= 7'h00;
            error_monitor_ff <= 2'h3;
            error_flag_ff <= 1'b1;
            memory_lock_state_ff <= 12'h000;
            zero_point_offset_ff <= 12'h000;
            direction_quadrature_config_ff <=
                `RESET_DIRECTION_QUADRATURE_CONFIG;
            fault_detect_disable_ff <= 12'h000;
            commutation_config_ff <= 12'h000;
            mem_rd_pend_ff <= 1'b0;
        end else if (cs_n_ff) begin
            bit_cnt_ff <= 5'd0;
            out_left_ff <= 5'd0;
            mem_rd_pend_ff <= 1'b0;
            spi_miso_oe_ff <= 1'b0;
        end else begin
            if (mem_rd_pend_ff) begin
                mem_rd_pend_ff <= 1'b0;
                shift_out_ff <= {mem_rd_data, 4'h0};
                out_left_ff <= 5'd12;
            end
            if (sclk_rise) begin
                shift_in_ff <= frame;
                if (bit_cnt_ff != 5'd31) begin
                    bit_cnt_ff <= bit_cnt_ff + 5'd1;
                end
                if (bit_cnt_ff == `OPCODE_BITS - 1) begin
                    if (frame[3:0] == `OP_ANGLE_READ) begin
                        shift_out_ff <= angle_frame;
                        out_left_ff <= 5'd16;
                    end else if (frame[3:0] == `OP_ANGLE_RENEW) begin
                        angle_value_ff <= held_angle_ff;
                        flux_strength_ff <= field_mt;
                        error_monitor_ff <= {~flux_fault, ~tracking_lost};
                        error_flag_ff <= ~(flux_fault | tracking_lost);
                    end
                end
                if (bit_cnt_ff == `ADDR_END_BIT - 1) begin
                    if (addr_op == `OP_REG_READ && rd_ok) begin
                        shift_out_ff <= {rd_val, 4'h0};
                        out_left_ff <= 5'd12;
                    end else if (addr_op == `OP_MEM_READ && user_mode_ff
                            && addr[6:4] == 3'h0) begin
                        mem_rd_pend_ff <= 1'b1;
                    end
                end
                if (bit_cnt_ff == `DATA_END_BIT - 1) begin
                    if (frame[22:19] == `OP_MODE_CHANGE && frame[18:12] ==
                            `ADDR_OPERATING_MODE_SELECT) begin
                        if (frame[11:0] == `MODE_USER_VALUE) begin
                            user_mode_ff <= 1'b1;
                        end else if (frame[11:0] == `MODE_NORMAL_VALUE) begin
                            user_mode_ff <= 1'b0;
                        end
                    end else if (frame[22:19] == `OP_REG_WRITE
                            && user_mode_ff) begin
                        if (frame[18:12] == `ADDR_ZERO_POINT_OFFSET) begin
                            zero_point_offset_ff <= frame[11:0];
                        end else if (frame[18:12] ==
                                `ADDR_DIRECTION_QUADRATURE_CONFIG) begin
                            direction_quadrature_config_ff <= frame[11:0];
                        end else if (frame[18:12] ==
                                `ADDR_FAULT_DETECT_DISABLE) begin
                            fault_detect_disable_ff <= frame[11:0];
                        end else if (frame[18:12] ==
                                `ADDR_COMMUTATION_CONFIG) begin
                            commutation_config_ff <= frame[11:0];
                        end
                    end
                end
            end
            // Shift on the falling edge so the host samples on the rise.
            if (sclk_fall) begin
                if (out_left_ff != 5'd0) begin
                    spi_miso_oe_ff <= 1'b1;
                    spi_miso_ff <= shift_out_ff[15];
                    shift_out_ff <= {shift_out_ff[14:0], 1'b0};
                    out_left_ff <= out_left_ff - 5'd1;
                end else begin
                    spi_miso_oe_ff <= 1'b0;
                end
            end
        end
    end
endmodule // angle_sensor_spi_command_port
`default_nettype wire

// ### angle_spi_map.vh
// Offsets, field positions, opcodes, reset values and frame bit counts.
`ifndef ANGLE_SPI_MAP_VH
`define ANGLE_SPI_MAP_VH
`define OP_MEM_WRITE 4'h1
`define OP_MEM_READ 4'h2
`define OP_REG_WRITE 4'h3
`define OP_REG_READ 4'h4
`define OP_MODE_CHANGE 4'h5
`define OP_ANGLE_RENEW 4'h8
`define OP_ANGLE_READ 4'h9
`define ADDR_ANGLE_VALUE 7'h00
`define ADDR_FLUX_STRENGTH 7'h01
`define ADDR_OPERATING_MODE_SELECT 7'h02
`define ADDR_ERROR_MONITOR 7'h03
`define ADDR_ZERO_POINT_OFFSET 7'h06
`define ADDR_DIRECTION_QUADRATURE_CONFIG 7'h07
`define ADDR_MEMORY_LOCK_STATE 7'h08
`define ADDR_FAULT_DETECT_DISABLE 7'h09
`define ADDR_COMMUTATION_CONFIG 7'h0a
`define MODE_NORMAL_VALUE 12'h000
`define MODE_USER_VALUE 12'h50f
`define RESET_DIRECTION_QUADRATURE_CONFIG 12'h020
`define HYS_MSB 5
`define HYS_LSB 4
`define ERRMON_FLUX_BIT 1
`define ERRMON_TRACK_BIT 0
`define OPCODE_BITS 4
`define ADDR_END_BIT 11
`define DATA_END_BIT 23
`define MEM_WORDS 16
`endif

// ### angle_spi_mem.v
// Small word store standing in for the nonvolatile memory, registered read.
`timescale 1ns/1ps
`default_nettype none
module angle_spi_mem (
    input wire sys_clk,
    input wire wr_en,
    input wire [3:0] wr_addr,
    input wire [11:0] wr_data,
    input wire [3:0] rd_addr,
    output reg [11:0] rd_data_ff
);
    reg [11:0] mem [0:15];
    integer i;
    initial begin
        for (i = 0; i < 16; i = i + 1) begin
            mem[i] = 12'h000;
        end
    end
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule // angle_spi_mem
`default_nettype wire

// ### angle_port_checker_assertions.sv
// Concurrent checks on the serial command port's pins and config outputs.
`timescale 1ns/1ps
`default_nettype none
module angle_port_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_miso_ff,
    input wire logic spi_miso_oe_ff,
    input wire logic user_mode_ff,
    input wire logic [11:0] zero_point_offset_ff,
    input wire logic [11:0] direction_quadrature_config_ff,
    input wire logic [11:0] fault_detect_disable_ff,
    input wire logic [11:0] commutation_config_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic [47:0] cfg = {zero_point_offset_ff,
        direction_quadrature_config_ff, fault_detect_disable_ff,
        commutation_config_ff};
    sequence cs_idle;
        spi_cs_n [*8];
    endsequence
    sequence oe_hold;
        spi_miso_oe_ff [*8];
    endsequence
    idle_off_a: assert property (cs_idle |-> !spi_miso_oe_ff)
        else $error("miso driven while chip select idle");
    reset_state_a: assert property (disable iff (1'b0) sys_rst |=>
        !user_mode_ff && !spi_miso_oe_ff &&
        direction_quadrature_config_ff == 12'h020)
        else $error("wrong state after reset");
    oe_start_a: assert property ($rose(spi_miso_oe_ff) |->
        !spi_cs_n && !spi_sclk)
        else $error("drive began outside a low clock phase of a frame");
    oe_hold_a: assert property ($rose(spi_miso_oe_ff) |=> oe_hold)
        else $error("reply drive dropped too early");
    miso_edge_a: assert property (spi_miso_oe_ff &&
        $changed(spi_miso_ff) |-> !spi_sclk)
        else $error("miso changed while serial clock high");
    mode_cs_a: assert property ($changed(user_mode_ff) |-> !spi_cs_n)
        else $error("mode changed outside a frame");
    cfg_cs_a: assert property ($changed(cfg) |-> !spi_cs_n)
        else $error("config changed outside a frame");
    normal_cfg_a: assert property (!user_mode_ff &&
        !$past(user_mode_ff, 3) |-> $stable(cfg))
        else $error("config changed in normal mode");
endmodule // angle_port_checker
`default_nettype wire

// ### angle_spi_host_model.sv
// Behavioural SPI host that frames commands and gathers the reply bits.
`timescale 1ns/1ps
`default_nettype none
module angle_spi_host_model (
    input wire logic sys_clk,
    input wire logic miso,
    input wire logic oe,
    output logic cs_n,
    output logic sclk,
    output logic mosi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // A released miso reads as the inverse of the last bit, never a copy.
    task automatic xfer(input int n, input logic [22:0] tx, input int idle,
                        output logic [15:0] rx, output int drv);
        rx = 16'h0000;
        drv = 0;
        cs_n <= 1'b0;
        tick(8);
        for (int i = n - 1; i >= 0; i--) begin
            mosi <= tx[i];
            tick(8);
            sclk <= 1'b1;
            tick(1);
            rx = {rx[14:0], oe ? miso : ~rx[0]};
            drv += oe;
            tick(7);
            sclk <= 1'b0;
        end
        tick(8);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        tick(idle);
    endtask
endmodule // angle_spi_host_model
`default_nettype wire

// ### angle_sensor_spi_command_port_tb.sv
// Self-checking bench for the angle sensor serial command port.
`timescale 1ns/1ps
`default_nettype none
`include "angle_spi_map.vh"
module angle_sensor_spi_command_port_tb;
    logic sys_clk, sys_rst, spi_cs_n, spi_sclk, spi_mosi, spi_miso_ff;
    logic spi_miso_oe_ff, flux_fault, tracking_lost, user_mode_ff;
    logic [11:0] raw_angle, zero_point_offset_ff, commutation_config_ff;
    logic [11:0] direction_quadrature_config_ff, fault_detect_disable_ff;
    logic [6:0] field_mt;
    logic [15:0] rx;
    int drv, error_cnt = 0, check_count = 0, cyc = 0;
    logic [3:0] ops [9] = '{4'h0, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'hd,
        4'he, 4'hf};
    logic [6:0] rw_a [4] = '{7'h06, 7'h07, 7'h09, 7'h0a};
    logic [11:0] rw_v [4] = '{12'h123, 12'h00f, 12'habc, 12'h3c5};
    angle_sensor_spi_command_port uut (.*);
    angle_spi_host_model host (
        .sys_clk(sys_clk),
        .miso(spi_miso_ff),
        .oe(spi_miso_oe_ff),
        .cs_n(spi_cs_n),
        .sclk(spi_sclk),
        .mosi(spi_mosi)
    );
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // About 22k cycles are needed; the ceiling leaves ample margin.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            results;
        end
    end
    task automatic results;
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register writes and mode changes get the long idle gap that a register write demands.
    task automatic frame(input logic [3:0] op, input logic [6:0] a,
                         input logic [11:0] d, input int n);
        host.xfer(n, {op, a, d} >> (23 - n), (op == `OP_REG_WRITE ||
            op == `OP_MODE_CHANGE) ? 500 : 16, rx, drv);
    endtask
    task automatic rd(input logic [6:0] a);
        frame(`OP_REG_READ, a, 12'h000, 23);
    endtask
    task automatic wr(input logic [6:0] a, input logic [11:0] d);
        frame(`OP_REG_WRITE, a, d, 23);
    endtask
    function automatic logic [15:0] afr(input logic m, input logic [11:0] a,
                                        input logic bad);
        return {m, ~^a[11:6] ^ bad, ~^a[5:0] ^ bad, ~bad, a};
    endfunction
    task automatic angle(input logic [11:0] later, input logic [15:0] exp);
        frame(`OP_ANGLE_RENEW, 7'h00, 12'h000, 4);
        raw_angle <= later;
        frame(`OP_ANGLE_READ, 7'h00, 12'h000, 20);
        check(rx, exp);
        check(drv, 16);
    endtask
    task automatic t_normal;
        check({user_mode_ff, spi_miso_oe_ff, direction_quadrature_config_ff,
            zero_point_offset_ff | commutation_config_ff},
            {2'b00, `RESET_DIRECTION_QUADRATURE_CONFIG, 12'h000});
        angle(12'h000, afr(1'b0, 12'h000, 1'b0));
        flux_fault <= 1'b1;
        angle(12'h000, afr(1'b0, 12'h000, 1'b1));
        flux_fault <= 1'b0;
        rd(7'h01);
        check(drv, 0);
        rd(`ADDR_ANGLE_VALUE);
        check({drv[7:0], rx[11:0]}, {8'd12, 12'h000});
        wr(7'h06, 12'h155);
        check(zero_point_offset_ff, 12'h000);
        wr(`ADDR_OPERATING_MODE_SELECT, `MODE_USER_VALUE);
        check(user_mode_ff, 1'b0);
        foreach (ops[i]) begin
            frame(ops[i], 7'h02, `MODE_USER_VALUE, 23);
            check({user_mode_ff, drv[4:0]}, 6'h00);
        end
    endtask
    task automatic t_user;
        frame(`OP_MODE_CHANGE, 7'h02, `MODE_USER_VALUE, 23);
        check(user_mode_ff, 1'b1);
        field_mt <= 7'h2a;
        flux_fault <= 1'b1;
        wr(7'h01, 12'hfff);
        frame(`OP_ANGLE_RENEW, 7'h00, 12'h000, 4);
        rd(7'h01);
        check(rx[11:0], 12'h02a);
        rd(7'h03);
        check(rx[11:0], 12'h001);
        rd(7'h02);
        check(rx[11:0], `MODE_USER_VALUE);
        rd(7'h08);
        check(drv, 12);
        rd(7'h04);
        check(drv, 0);
        frame(`OP_MEM_READ, 7'h03, 12'h000, 23);
        check({drv[7:0], rx[11:0]}, {8'd12, 12'h000});
        flux_fault <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(rw_a[i], rw_v[i]);
            check(drv, 0);
            rd(rw_a[i]);
            check(rx[11:0], rw_v[i]);
        end
        check({zero_point_offset_ff, direction_quadrature_config_ff,
            fault_detect_disable_ff, commutation_config_ff},
            {rw_v[0], rw_v[1], rw_v[2], rw_v[3]});
    endtask
    // Offset and detect-disable are cleared so the angle passes unaltered.
    task automatic t_user_angle;
        wr(7'h06, 12'h000);
        wr(7'h09, 12'h000);
        raw_angle <= 12'ha53;
        angle(12'h3c0, afr(1'b1, 12'ha53, 1'b0));
        raw_angle <= 12'ha53;
        wr(7'h07, 12'h04f);
        raw_angle <= 12'ha54;
        tracking_lost <= 1'b1;
        angle(12'ha54, afr(1'b1, 12'ha53, 1'b1));
        frame(`OP_MODE_CHANGE, 7'h02, `MODE_NORMAL_VALUE, 23);
        check(user_mode_ff, 1'b0);
        // A memory write needs a very long idle after it, so it ends the run.
        frame(`OP_MODE_CHANGE, 7'h02, `MODE_USER_VALUE, 23);
        frame(`OP_MEM_WRITE, 7'h05, 12'h5a5, 23);
        check({user_mode_ff, drv[4:0]}, 6'h20);
    endtask
    initial begin
        sys_rst = 1'b1;
        raw_angle = 12'h000;
        field_mt = 7'h00;
        flux_fault = 1'b0;
        tracking_lost = 1'b0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge sys_clk);
        t_normal;
        t_user;
        t_user_angle;
        results;
    end
endmodule // angle_sensor_spi_command_port_tb
bind angle_sensor_spi_command_port angle_port_checker chk (.*);
`default_nettype wire
